// ---- logic/imu_power_defines.vh ----
// register map, field layout, reset values and timing for the power-mode and data-shadow block
// Functional notes
// - no accel or gyro enabled with power save set gives suspend, configuration kept.
// - no accel or gyro enabled with power save clear gives configuration mode.
// - enabled sensor lacking aliasing-free filtering with power save set gives low power.
// - enabled sensors filtered, gyro low-noise clear gives normal; power save ignored.
// - enabled sensors filtered, gyro enabled with low-noise set gives performance; accel same as normal.
// - every combination of enable, filter, noise and power-save bits decodes to one mode.
// - separate accel, gyro, aux and temperature enables, all clear after reset.
// - mode changes never clear registers or buffered FIFO contents.
// - power mode alters startup and functions only; quality follows filter selections.
// - gyro low-noise selector drives the precision rate-sensing configuration.
// - power save set reduces internal power without degrading configured quality.
// - FIFO logs in all modes; FIFO reads need power save clear first.
// - unrestricted access returns 450 us after power save is cleared.
// - each accel axis is a 16-bit value in low/high bytes, data 8 to 13.
// - low byte read freezes matching high byte until that high byte is read.
// - accel bandwidth field picks filter mode; 0x02 is normal filter mode.
// - reset comes up with power save set, hence in suspend.
`ifndef IMU_POWER_DEFINES_VH
`define IMU_POWER_DEFINES_VH

// byte addresses
`define ADDR_SENSOR_ENABLE   8'h00
`define ADDR_POWER_CONFIG    8'h04
`define ADDR_ACCEL_CONFIG    8'h08
`define ADDR_GYRO_CONFIG     8'h0C
`define ADDR_STATUS          8'h10
// data register indices; byte address is four times the index
`define DATA_FIRST_INDEX     6'h08
`define DATA_LAST_INDEX      6'h0D

// sensor enable fields
`define EN_ACC_BIT           0
`define EN_GYR_BIT           1
`define EN_AUX_BIT           2
`define EN_TEMP_BIT          3
`define SENSOR_ENABLE_RESET  4'h0
// power config fields
`define APS_BIT              0
`define POWER_CONFIG_RESET   1'h1
// accel config fields
`define ACC_ODR_MSB          3
`define ACC_BWP_MSB          6
`define ACC_BWP_LSB          4
`define ACC_PERF_BIT         7
`define ACCEL_CONFIG_RESET   8'hA8
`define ACC_BWP_NORMAL       3'h2
// gyro config fields
`define GYR_BWP_MSB          5
`define GYR_BWP_LSB          4
`define GYR_NOISE_BIT        6
`define GYR_PERF_BIT         7
`define GYRO_CONFIG_RESET    8'hA9
// status fields
`define ST_MODE_MSB          4
`define ST_READY_BIT         5
`define ST_SPACING_BIT       6
`define ST_FILTER_NORMAL_BIT 7

// one-hot power modes
`define MODE_SUSPEND         5'h01
`define MODE_CONFIG          5'h02
`define MODE_LOW_POWER       5'h04
`define MODE_NORMAL          5'h08
`define MODE_PERFORMANCE     5'h10

// timing
`define APS_DELAY_US         450
`define CLOCK_MHZ            100
`define APS_DELAY_CYCLES     (`APS_DELAY_US * `CLOCK_MHZ)

`endif

// ---- logic/imu_power_shadow.v ----
// power-mode decode, power-config registers and accelerometer data shadowing behind APB
`timescale 1ns/1ps
`include "imu_power_defines.vh"
module imu_power_shadow #(
   parameter DELAY_CYCLES = `APS_DELAY_CYCLES,
   parameter CNT_W        = 16
) (
   // clock and reset
   input  wire        mclk,
   input  wire        arst_n,
   // apb slave
   input  wire        psel,
   input  wire        penable,
   input  wire        pwrite,
   input  wire [7:0]  paddr,
   input  wire [31:0] pwdata,
   output reg  [31:0] prdata,
   output reg         pready,
   output reg         pslverr,
   // accelerometer samples
   input  wire [15:0] accel_x,
   input  wire [15:0] accel_y,
   input  wire [15:0] accel_z,
   input  wire        accel_sample_valid,
   // power and quality controls to the analog front end
   output reg  [4:0]  power_mode,
   output reg         accel_active,
   output reg         gyro_active,
   output reg         aux_active,
   output reg         temp_active,
   output reg         power_reduce,
   output reg         accel_aliasing_free,
   output reg  [2:0]  accel_filter_mode,
   output reg         gyro_aliasing_free,
   output reg         gyro_low_noise,
   output reg  [1:0]  gyro_filter_mode,
   output reg         access_ready,
   output reg         fifo_read_allowed
);

   localparam [4:0] ST_SUSPEND     = `MODE_SUSPEND;
   localparam [4:0] ST_CONFIG      = `MODE_CONFIG;
   localparam [4:0] ST_LOW_POWER   = `MODE_LOW_POWER;
   localparam [4:0] ST_NORMAL      = `MODE_NORMAL;
   localparam [4:0] ST_PERFORMANCE = `MODE_PERFORMANCE;
   localparam [CNT_W-1:0] DELAY    = DELAY_CYCLES[CNT_W-1:0];

   reg  [3:0]       sensor_enable_reg;
   reg              power_config_reg;
   reg  [7:0]       accel_config_reg;
   reg  [7:0]       gyro_config_reg;
   reg  [4:0]       mode_reg;
   reg  [4:0]       mode_next;
   reg  [CNT_W-1:0] ready_cnt_reg;
   reg  [CNT_W-1:0] space_cnt_reg;
   reg              spacing_err_reg;
   reg  [7:0]       data_low_reg  [0:2];
   reg  [7:0]       data_high_reg [0:2];
   reg  [7:0]       shadow_reg    [0:2];
   reg  [2:0]       lock_reg;
   reg  [31:0]      rdata_next;
   reg              err_next;
   integer          i;

   wire        setup    = psel & ~penable;
   wire        done     = psel & penable & pready;
   wire        wr_done  = done & pwrite;
   wire        rd_setup = setup & ~pwrite;
   wire [5:0]  index    = paddr[7:2];
   wire        is_data  = (index >= `DATA_FIRST_INDEX) && (index <= `DATA_LAST_INDEX);
   wire [5:0]  data_rel = index - `DATA_FIRST_INDEX;
   wire [2:0]  data_off = data_rel[2:0];
   wire [1:0]  axis     = data_off[2:1];
   wire        is_high  = data_off[0];

   // mode decode for any setting combination
   function [4:0] decode_mode;
      input acc_en;
      input gyr_en;
      input acc_perf;
      input gyr_perf;
      input gyr_noise;
      input aps;
      reg   unfiltered;
      begin
         unfiltered = (acc_en & ~acc_perf) | (gyr_en & ~gyr_perf);
         if (!acc_en && !gyr_en) begin
            decode_mode = aps ? ST_SUSPEND : ST_CONFIG;
         end else if (unfiltered && aps) begin
            decode_mode = ST_LOW_POWER;
         end else if (gyr_en && gyr_noise && !unfiltered) begin
            decode_mode = ST_PERFORMANCE;
         end else begin
            decode_mode = ST_NORMAL;
         end
      end
   endfunction

   function [7:0] axis_byte;
      input [15:0] sample;
      input        high;
      begin
         axis_byte = high ? sample[15:8] : sample[7:0];
      end
   endfunction

   always @* begin
      mode_next = decode_mode(sensor_enable_reg[`EN_ACC_BIT], sensor_enable_reg[`EN_GYR_BIT],
                              accel_config_reg[`ACC_PERF_BIT], gyro_config_reg[`GYR_PERF_BIT],
                              gyro_config_reg[`GYR_NOISE_BIT], power_config_reg);
   end

   // read data and error, captured in the setup cycle
   always @* begin
      rdata_next = 32'h0000_0000;
      err_next   = 1'b0;
      if (is_data) begin
         if (is_high) begin
            rdata_next[7:0] = lock_reg[axis] ? shadow_reg[axis] : data_high_reg[axis];
         end else begin
            rdata_next[7:0] = data_low_reg[axis];
         end
      end else begin
         case (paddr)
            `ADDR_SENSOR_ENABLE: rdata_next[3:0] = sensor_enable_reg;
            `ADDR_POWER_CONFIG:  rdata_next[`APS_BIT] = power_config_reg;
            `ADDR_ACCEL_CONFIG:  rdata_next[7:0] = accel_config_reg;
            `ADDR_GYRO_CONFIG:   rdata_next[7:0] = gyro_config_reg;
            `ADDR_STATUS: begin
               rdata_next[`ST_MODE_MSB:0]        = mode_reg;
               rdata_next[`ST_READY_BIT]         = access_ready;
               rdata_next[`ST_SPACING_BIT]       = spacing_err_reg;
               rdata_next[`ST_FILTER_NORMAL_BIT] =
                  (accel_config_reg[`ACC_BWP_MSB:`ACC_BWP_LSB] == `ACC_BWP_NORMAL);
            end
            default: err_next = 1'b1;
         endcase
      end
   end

   // apb handshake: one wait-free access phase
   always @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         prdata  <= 32'h0000_0000;
         pready  <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         pready <= setup;
         if (setup) begin
            prdata  <= pwrite ? 32'h0000_0000 : rdata_next;
            pslverr <= err_next;
         end else if (done) begin
            pslverr <= 1'b0;
         end
      end
   end

   // control registers, kept across every mode change
   always @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         sensor_enable_reg <= `SENSOR_ENABLE_RESET;
         power_config_reg  <= `POWER_CONFIG_RESET;
         accel_config_reg  <= `ACCEL_CONFIG_RESET;
         gyro_config_reg   <= `GYRO_CONFIG_RESET;
      end else if (wr_done) begin
         case (paddr)
            `ADDR_SENSOR_ENABLE: sensor_enable_reg <= pwdata[3:0];
            `ADDR_POWER_CONFIG:  power_config_reg  <= pwdata[`APS_BIT];
            `ADDR_ACCEL_CONFIG:  accel_config_reg  <= pwdata[7:0];
            `ADDR_GYRO_CONFIG:   gyro_config_reg   <= pwdata[7:0];
            default: ;
         endcase
      end
   end

   // power mode state follows the decode
   always @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         mode_reg <= ST_SUSPEND;
      end else begin
         case (mode_next)
            ST_SUSPEND, ST_CONFIG, ST_LOW_POWER, ST_NORMAL, ST_PERFORMANCE: mode_reg <= mode_next;
            default: mode_reg <= ST_CONFIG;
         endcase
      end
   end

   // access delay after power save is cleared, and write spacing under power save
   always @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         ready_cnt_reg   <= {CNT_W{1'b0}};
         space_cnt_reg   <= {CNT_W{1'b0}};
         spacing_err_reg <= 1'b0;
      end else begin
         if (power_config_reg) begin
            ready_cnt_reg <= {CNT_W{1'b0}};
         end else if (ready_cnt_reg < DELAY) begin
            ready_cnt_reg <= ready_cnt_reg + 1'b1;
         end
         if (wr_done) begin
            space_cnt_reg <= {CNT_W{1'b0}};
         end else if (space_cnt_reg < DELAY) begin
            space_cnt_reg <= space_cnt_reg + 1'b1;
         end
         if (wr_done && power_config_reg && space_cnt_reg < DELAY) begin
            spacing_err_reg <= 1'b1;
         end else if (wr_done && paddr == `ADDR_STATUS && pwdata[`ST_SPACING_BIT]) begin
            spacing_err_reg <= 1'b0;
         end
      end
   end

   // accelerometer sample registers with high-byte shadowing
   always @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         for (i = 0; i < 3; i = i + 1) begin
            data_low_reg[i]  <= 8'h00;
            data_high_reg[i] <= 8'h00;
            shadow_reg[i]    <= 8'h00;
         end
         lock_reg <= 3'h0;
      end else begin
         if (accel_sample_valid && sensor_enable_reg[`EN_ACC_BIT]) begin
            data_low_reg[0]  <= axis_byte(accel_x, 1'b0);
            data_high_reg[0] <= axis_byte(accel_x, 1'b1);
            data_low_reg[1]  <= axis_byte(accel_y, 1'b0);
            data_high_reg[1] <= axis_byte(accel_y, 1'b1);
            data_low_reg[2]  <= axis_byte(accel_z, 1'b0);
            data_high_reg[2] <= axis_byte(accel_z, 1'b1);
         end
         if (rd_setup && is_data && !is_high) begin
            shadow_reg[axis] <= data_high_reg[axis];
            lock_reg[axis]   <= 1'b1;
         end else if (rd_setup && is_data && is_high) begin
            lock_reg[axis]   <= 1'b0;
         end
      end
   end

   // outputs to the sensor front end
   always @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         power_mode          <= ST_SUSPEND;
         accel_active        <= 1'b0;
         gyro_active         <= 1'b0;
         aux_active          <= 1'b0;
         temp_active         <= 1'b0;
         power_reduce        <= 1'b1;
         accel_aliasing_free <= 1'b0;
         accel_filter_mode   <= 3'h0;
         gyro_aliasing_free  <= 1'b0;
         gyro_low_noise      <= 1'b0;
         gyro_filter_mode    <= 2'h0;
         access_ready        <= 1'b0;
         fifo_read_allowed   <= 1'b0;
      end else begin
         power_mode          <= mode_reg;
         accel_active        <= sensor_enable_reg[`EN_ACC_BIT];
         gyro_active         <= sensor_enable_reg[`EN_GYR_BIT];
         aux_active          <= sensor_enable_reg[`EN_AUX_BIT];
         temp_active         <= sensor_enable_reg[`EN_TEMP_BIT];
         power_reduce        <= power_config_reg;
         // quality comes only from the filter fields, never from the mode
         accel_aliasing_free <= accel_config_reg[`ACC_PERF_BIT];
         accel_filter_mode   <= accel_config_reg[`ACC_BWP_MSB:`ACC_BWP_LSB];
         gyro_aliasing_free  <= gyro_config_reg[`GYR_PERF_BIT];
         gyro_low_noise      <= gyro_config_reg[`GYR_NOISE_BIT];
         gyro_filter_mode    <= gyro_config_reg[`GYR_BWP_MSB:`GYR_BWP_LSB];
         access_ready        <= !power_config_reg && ready_cnt_reg >= DELAY;
         fifo_read_allowed   <= !power_config_reg && ready_cnt_reg >= DELAY;
      end
   end

endmodule

// ---- testbench/imu_power_shadow_asserts.sv ----
// concurrent checks on the power-mode and readiness outputs
`timescale 1ns/1ps
`include "imu_power_defines.vh"
module imu_power_shadow_asserts #(
   parameter DELAY_CYCLES = 20
) (
   // clock and reset
   input wire       mclk,
   input wire       arst_n,
   // watched outputs
   input wire [4:0] power_mode,
   input wire       accel_active,
   input wire       gyro_active,
   input wire       aux_active,
   input wire       temp_active,
   input wire       power_reduce,
   input wire       accel_aliasing_free,
   input wire       gyro_aliasing_free,
   input wire       gyro_low_noise,
   input wire       access_ready,
   input wire       fifo_read_allowed
);
   int low_cnt;

   // cycles since power save was last seen set
   always @(posedge mclk or negedge arst_n) begin
      if (!arst_n) low_cnt <= 0;
      else if (power_reduce) low_cnt <= 0;
      else if (low_cnt < DELAY_CYCLES + 8) low_cnt <= low_cnt + 1;
   end

   default clocking @(posedge mclk); endclocking
   default disable iff (!arst_n);

   sequence idle_save;
      (!accel_active && !gyro_active && power_reduce) [*3];
   endsequence
   sequence idle_open;
      (!accel_active && !gyro_active && !power_reduce) [*3];
   endsequence
   sequence acc_raw_save;
      (accel_active && !accel_aliasing_free && !gyro_active && power_reduce) [*3];
   endsequence
   sequence acc_filtered;
      (accel_active && accel_aliasing_free && !gyro_active) [*3];
   endsequence
   sequence gyro_precise;
      (gyro_active && gyro_aliasing_free && gyro_low_noise && (!accel_active || accel_aliasing_free)) [*3];
   endsequence

   a_suspend_idle: assert property (idle_save |-> power_mode == `MODE_SUSPEND)
      else $error("suspend mode expected");
   a_config_idle: assert property (idle_open |-> power_mode == `MODE_CONFIG)
      else $error("configuration mode expected");
   a_low_power: assert property (acc_raw_save |-> power_mode == `MODE_LOW_POWER)
      else $error("low power mode expected");
   a_normal_mode: assert property (acc_filtered |-> power_mode == `MODE_NORMAL)
      else $error("normal mode expected");
   a_perf_mode: assert property (gyro_precise |-> power_mode == `MODE_PERFORMANCE)
      else $error("performance mode expected");
   a_mode_onehot: assert property ($onehot(power_mode))
      else $error("power mode not one-hot");
   a_reset_suspend: assert property ($rose(arst_n) |-> power_mode == `MODE_SUSPEND && power_reduce)
      else $error("reset did not leave suspend with power save");
   a_enables_reset: assert property ($rose(arst_n) |-> !(accel_active | gyro_active | aux_active | temp_active))
      else $error("sensor enabled after reset");
   a_ready_early: assert property (access_ready |-> low_cnt >= DELAY_CYCLES - 4)
      else $error("access ready before the delay");
   a_ready_late: assert property (low_cnt == DELAY_CYCLES + 4 |-> access_ready && fifo_read_allowed)
      else $error("access ready missing after the delay");
endmodule

bind imu_power_shadow imu_power_shadow_asserts #(.DELAY_CYCLES(DELAY_CYCLES)) u_imu_power_shadow_asserts (
   .mclk(mclk), .arst_n(arst_n), .power_mode(power_mode), .accel_active(accel_active),
   .gyro_active(gyro_active), .aux_active(aux_active), .temp_active(temp_active),
   .power_reduce(power_reduce), .accel_aliasing_free(accel_aliasing_free),
   .gyro_aliasing_free(gyro_aliasing_free), .gyro_low_noise(gyro_low_noise),
   .access_ready(access_ready), .fifo_read_allowed(fifo_read_allowed));

// ---- testbench/imu_host_model.sv ----
// apb host model that keeps the write spacing under power save
`timescale 1ns/1ps
module imu_host_model #(
   parameter DELAY_CYCLES = 20
) (
   // clock
   input  wire        mclk,
   // apb master
   output reg         psel,
   output reg         penable,
   output reg         pwrite,
   output reg  [7:0]  paddr,
   output reg  [31:0] pwdata,
   input  wire [31:0] prdata,
   input  wire        pready,
   input  wire        pslverr
);
   reg  aps     = 1'b1;
   reg  rush    = 1'b0;
   time last_wr = 0;

   initial begin
      {psel, penable, pwrite, paddr, pwdata} <= '0;
   end

   task automatic xfer(input [7:0] a, input w, input [31:0] d, output [31:0] q, output e);
      int n;
      // writes under power save wait out the gap unless told to rush
      while (w && aps && !rush && $time - last_wr < (DELAY_CYCLES + 2) * 10) @(posedge mclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge mclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge mclk);
         n++;
      end while (pready !== 1'b1 && n < 16);
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (pready !== 1'b1) begin
         imu_power_shadow_tb.mismatches++;
         imu_power_shadow_tb.give_verdict();
      end
      if (w) last_wr = $time;
      if (w && a == 8'h04) aps = d[0];
      @(posedge mclk);
   endtask
endmodule

// ---- testbench/imu_power_shadow_tb.sv ----
// self-checking bench for the power-mode and data-shadow block
`timescale 1ns/1ps
module imu_power_shadow_tb;
   localparam DLY = 20;
   logic        mclk;
   logic        arst_n = 1'b0;
   logic        accel_sample_valid = 1'b0;
   logic [15:0] s [3] = '{16'h0, 16'h0, 16'h0};
   logic [15:0] a [3] = '{16'h1234, 16'h5678, 16'h9ABC};
   logic [15:0] b [3] = '{16'hFEDC, 16'hBA98, 16'h7654};
   // rows: enables, power save, accel config, gyro config, mode
   logic [39:0] tbl [11] = '{40'h00_01_A8_A9_01, 40'h00_00_A8_A9_02, 40'h01_01_28_A9_04,
      40'h02_01_A8_29_04, 40'h03_01_28_29_04, 40'h01_01_A8_A9_08, 40'h03_00_A8_A9_08,
      40'h02_00_A8_E9_10, 40'h03_01_A8_E9_10, 40'h01_00_28_A9_08, 40'h0C_00_98_E9_02};
   wire         psel, penable, pwrite, pready, pslverr;
   wire [7:0]   paddr;
   wire [31:0]  pwdata, prdata;
   wire [4:0]   power_mode;
   wire [2:0]   accel_filter_mode;
   wire [1:0]   gyro_filter_mode;
   wire         accel_active, gyro_active, aux_active, temp_active, power_reduce;
   wire         accel_aliasing_free, gyro_aliasing_free, gyro_low_noise, access_ready, fifo_read_allowed;
   wire [9:0]   ctl_seen = {power_mode, temp_active, aux_active, gyro_active, accel_active, power_reduce};
   wire [7:0]   flt_seen = {accel_aliasing_free, accel_filter_mode,
                            gyro_aliasing_free, gyro_low_noise, gyro_filter_mode};
   int          mismatches = 0;
   int          check_count = 0;
   logic [31:0] q;
   logic        e;

   imu_power_shadow #(.DELAY_CYCLES(DLY)) u_imu_power_shadow (
      .mclk(mclk), .arst_n(arst_n), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .accel_x(s[0]), .accel_y(s[1]),
      .accel_z(s[2]), .accel_sample_valid(accel_sample_valid), .power_mode(power_mode),
      .accel_active(accel_active), .gyro_active(gyro_active), .aux_active(aux_active),
      .temp_active(temp_active), .power_reduce(power_reduce), .accel_aliasing_free(accel_aliasing_free),
      .accel_filter_mode(accel_filter_mode), .gyro_aliasing_free(gyro_aliasing_free),
      .gyro_low_noise(gyro_low_noise), .gyro_filter_mode(gyro_filter_mode), .access_ready(access_ready),
      .fifo_read_allowed(fifo_read_allowed));

   imu_host_model #(.DELAY_CYCLES(DLY)) u_imu_host_model (
      .mclk(mclk), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr));

   initial begin
      mclk = 1'b0;
      forever #5 mclk = ~mclk;
   end

   task check(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         mismatches++;
         $display("[FAIL] %0t: saw %h, expected %h", $time, got, exp);
      end
   endtask

   task give_verdict;
      if (mismatches == 0 && check_count > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask

   task wr(input [7:0] ad, input [31:0] d);
      u_imu_host_model.xfer(ad, 1'b1, d, q, e);
   endtask

   task rd(input [7:0] ad, input [31:0] x);
      u_imu_host_model.xfer(ad, 1'b0, 32'h0, q, e);
      check(q, x);
   endtask

   task smp(input [15:0] x, input [15:0] y, input [15:0] z);
      s <= '{x, y, z};
      accel_sample_valid <= 1'b1;
      @(posedge mclk);
      accel_sample_valid <= 1'b0;
      @(posedge mclk);
   endtask

   initial begin
      int          n;
      logic [39:0] t;
      repeat (6) @(posedge mclk);
      arst_n <= 1'b1;
      rd(8'h00, 32'h0);
      rd(8'h04, 32'h1);
      rd(8'h08, 32'hA8);
      rd(8'h0C, 32'hA9);
      rd(8'h10, 32'h81);
      rd(8'h18, 32'h0);
      check(32'(e), 32'h1);
      // two writes with no gap while power save is set
      u_imu_host_model.rush = 1'b1;
      wr(8'h08, 32'hA8);
      wr(8'h08, 32'hA8);
      u_imu_host_model.rush = 1'b0;
      rd(8'h10, 32'hC1);
      wr(8'h10, 32'h40);
      rd(8'h10, 32'h81);
      foreach (tbl[i]) begin
         t = tbl[i];
         wr(8'h04, 32'(t[31:24]));
         wr(8'h08, 32'(t[23:16]));
         wr(8'h0C, 32'(t[15:8]));
         wr(8'h00, 32'(t[39:32]));
         u_imu_host_model.xfer(8'h10, 1'b0, 32'h0, q, e);
         check(32'({q[7], q[4:0]}), 32'({t[22:20] == 3'h2, t[4:0]}));
         check(32'(ctl_seen), 32'({t[4:0], t[35:32], t[24]}));
         check(32'(flt_seen), 32'({t[23:20], t[15:12]}));
      end
      rd(8'h08, 32'h98);
      rd(8'h0C, 32'hE9);
      wr(8'h04, 32'h1);
      wr(8'h04, 32'h0);
      check(32'({access_ready, fifo_read_allowed}), 32'h0);
      n = 0;
      while (access_ready !== 1'b1 && n < DLY + 20) begin
         @(posedge mclk);
         n++;
      end
      check(32'({n >= DLY - 4 && n <= DLY + 4, fifo_read_allowed}), 32'h3);
      rd(8'h10, 32'h22);
      wr(8'h08, 32'hA8);
      // samples are dropped while the accelerometer is disabled
      smp(b[0], b[1], b[2]);
      rd(8'h20, 32'h0);
      wr(8'h00, 32'h1);
      foreach (a[i]) begin
         smp(a[0], a[1], a[2]);
         rd(8'h20 + 8'(8 * i), 32'(a[i][7:0]));
         smp(b[0], b[1], b[2]);
         rd(8'h24 + 8'(8 * i), 32'(a[i][15:8]));
         rd(8'h24 + 8'(8 * i), 32'(b[i][15:8]));
      end
      give_verdict();
   end
endmodule
